/* rtl/cpwm_pkg.sv */
// Contract
// R1 - Complementary mode joins channels 3,4 up/down
// R2 - Channel 3 pair 1, channel 4 pairs 2,3
// R3 - Software preloads counter 4 zero, counter 3 margin
// R4 - Period register holds counter 3 limit minus 1
// R5 - Transition registers set pairs 1, 2, 3
// R6 - Software halts both counters before configuring
// R7 - Software picks same clock, no clear source
// R8 - Combination field selects complementary mode
// R9 - Software never preloads equal counter values
// R10 - Initial transition values not below counter 3 preload
// R11 - Re-entering mode repeats whole setup sequence
// R12 - Down at period match, up at underflow
// R13 - Match order counter 3,4,4,4,3 each cycle; the code matches 3,4,4,3 per pair
// R14 - Out-of-range transition gives constant duty
// R15 - Period flag only up, overflow only underflow
// R16 - Buffers copy at period match up, underflow
// R17 - Software changes transitions only via buffers
// R18 - Up-to-down transfer never crosses top range edge
// R19 - Down-to-up transfer never crosses bottom range edge
// R20 - Out and back transfers share counting direction
// R21 - Channel 2 quadrature counts both edges both inputs
// R22 - Phase mode forces external inputs, keeps rest
// R23 - Quadrature up/down edge conditions
// R24 - Both counters switch pair, margin gives dead time
// R25 - Overflow flag on wrap or underflow
// R26 - Level select bits invert complementary outputs
package cpwm_pkg;

  localparam int          CNT_W        = 16;

  localparam logic [7:0]  OFS_START    = 8'h00;
  localparam logic [7:0]  OFS_MODE     = 8'h04;
  localparam logic [7:0]  OFS_OUTCTL   = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_CNT2     = 8'h10;
  localparam logic [7:0]  OFS_CNT3     = 8'h14;
  localparam logic [7:0]  OFS_CNT4     = 8'h18;
  localparam logic [7:0]  OFS_PERIOD   = 8'h1C;
  localparam logic [7:0]  OFS_TR1      = 8'h20;
  localparam logic [7:0]  OFS_BUF1     = 8'h2C;
  localparam logic [7:0]  OFS_CMPA2    = 8'h38;
  localparam logic [7:0]  OFS_CMPB2    = 8'h3C;
  localparam logic [7:0]  OFS_CLR2     = 8'h40;
  localparam logic [7:0]  OFS_STEP     = 8'h04;

  localparam int          ST_CH2       = 0;
  localparam int          ST_CH3       = 1;
  localparam int          ST_CH4       = 2;
  localparam int          MD_BUF       = 2;
  localparam int          MD_PHASE     = 3;
  localparam logic [1:0]  COMB_COMPL   = 2'h3;
  localparam logic [1:0]  CLR_A        = 2'h1;
  localparam logic [1:0]  CLR_B        = 2'h2;

  localparam logic [2:0]  START_RST    = 3'h0;
  localparam logic [3:0]  MODE_RST     = 4'h0;
  localparam logic [1:0]  LVL_RST      = 2'h3;
  localparam logic [1:0]  CLR2_RST     = 2'h0;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] REG_RST      = 16'hFFFF;

  typedef struct packed {
    logic ovf2;
    logic cmpb2;
    logic cmpa2;
    logic ovf4;
    logic cmpa3;
  } flags_t;

  typedef struct packed {
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
  } edges_t;

endpackage

/* rtl/complementary_pwm_phase_count.sv */
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module complementary_pwm_phase_count
  import cpwm_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        ext_clock_a_i,
  input  wire logic        ext_clock_b_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             pwm1_out_o,
  output logic             pwm1_compl_out_o,
  output logic             pwm2_out_o,
  output logic             pwm2_compl_out_o,
  output logic             pwm3_out_o,
  output logic             pwm3_compl_out_o
);

  logic          acc;
  logic          wr;
  logic [31:0]   rdata;
  logic [2:0]    start_q;
  logic [3:0]    mode_q;
  logic [1:0]    lvl_q;
  logic [1:0]    clr2_q;
  flags_t        flags_q;
  flags_t        fset;
  flags_t        fclr;
  logic [CW-1:0] cnt2_q;
  logic [CW-1:0] cnt3_q;
  logic [CW-1:0] cnt4_q;
  logic [CW-1:0] per_q;
  logic [CW-1:0] cmpa2_q;
  logic [CW-1:0] cmpb2_q;
  logic [CW-1:0] tr_q [3];
  logic [CW-1:0] buf_q [3];
  logic [2:0]    pv_q;
  logic [2:0]    cv_q;
  logic          dir_q;
  logic          exta_q;
  logic          extb_q;
  logic          comp;
  logic          run34;
  logic          m3up;
  logic          uf4;
  logic          xfer;
  logic          up2;
  logic          dn2;
  logic          step2;
  logic          ma2;
  logic          mb2;
  logic          clr2;
  edges_t        edg;

  // Byte-lane merge of a write into a counter-wide register
  function automatic logic [CW-1:0] wmerge(
    input logic [CW-1:0] old,
    input logic [31:0]   d,
    input logic [3:0]    s
  );
    logic [CW-1:0] r;
    r = old;
    for (int i = 0; i < CW; i++) begin
      if (s[i/8]) begin
        r[i] = d[i];
      end
    end
    return r;
  endfunction

  // Write strobe for one register offset
  function automatic logic whit(input logic [7:0] a);
    return wr && (wb_adr_i == a);
  endfunction

  // Bus handshake
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = acc & wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      wb_dat_o <= rdata;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      OFS_START:  rdata = 32'(start_q);
      OFS_MODE:   rdata = 32'(mode_q);
      OFS_OUTCTL: rdata = 32'(lvl_q);
      OFS_STATUS: rdata = 32'(flags_q);
      OFS_CNT2:   rdata = 32'(cnt2_q);
      OFS_CNT3:   rdata = 32'(cnt3_q);
      OFS_CNT4:   rdata = 32'(cnt4_q);
      OFS_PERIOD: rdata = 32'(per_q);
      OFS_CMPA2:  rdata = 32'(cmpa2_q);
      OFS_CMPB2:  rdata = 32'(cmpb2_q);
      OFS_CLR2:   rdata = 32'(clr2_q);
      default: begin
        for (int k = 0; k < 3; k++) begin
          if (wb_adr_i == OFS_TR1 + 8'(k * 4)) begin
            rdata = 32'(tr_q[k]);
          end
          if (wb_adr_i == OFS_BUF1 + 8'(k * 4)) begin
            rdata = 32'(buf_q[k]);
          end
        end
      end
    endcase
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= START_RST;
      mode_q  <= MODE_RST;
      lvl_q   <= LVL_RST;
      clr2_q  <= CLR2_RST;
    end else begin
      if (whit(OFS_START) && wb_sel_i[0]) begin
        start_q <= wb_dat_i[2:0];
      end
      if (whit(OFS_MODE) && wb_sel_i[0]) begin
        mode_q <= wb_dat_i[3:0];
      end
      if (whit(OFS_OUTCTL) && wb_sel_i[0]) begin
        lvl_q <= wb_dat_i[1:0];
      end
      if (whit(OFS_CLR2) && wb_sel_i[0]) begin
        clr2_q <= wb_dat_i[1:0];
      end
    end
  end

  // Mode decode
  assign comp  = (mode_q[1:0] == COMB_COMPL);  // [R8]
  assign run34 = comp & start_q[ST_CH3] & start_q[ST_CH4];  // [R1]
  assign m3up  = run34 & ~dir_q & (cnt3_q == per_q);  // [R4] [R15]
  assign uf4   = run34 & dir_q & (cnt4_q == CNT_ZERO);  // [R15]
  assign xfer  = mode_q[MD_BUF] & (m3up | uf4);  // [R16]

  // Counting direction of the joined pair
  always_ff @(posedge clk_i) begin
    if (rst_i || !comp) begin
      dir_q <= 1'b0;
    end else if (m3up) begin
      dir_q <= 1'b1;  // [R12]
    end else if (uf4) begin
      dir_q <= 1'b0;  // [R12]
    end
  end

  // Counter 3, overshoots one past the limit at the turn
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt3_q <= CNT_ZERO;
    end else if (whit(OFS_CNT3)) begin
      cnt3_q <= wmerge(cnt3_q, wb_dat_i, wb_sel_i);
    end else if (run34) begin
      cnt3_q <= dir_q ? cnt3_q - 1'b1 : cnt3_q + 1'b1;  // [R1]
    end else if (!comp && start_q[ST_CH3]) begin
      cnt3_q <= cnt3_q + 1'b1;
    end
  end

  // Counter 4, undershoots one below zero at the turn
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt4_q <= CNT_ZERO;
    end else if (whit(OFS_CNT4)) begin
      cnt4_q <= wmerge(cnt4_q, wb_dat_i, wb_sel_i);
    end else if (run34) begin
      cnt4_q <= dir_q ? cnt4_q - 1'b1 : cnt4_q + 1'b1;  // [R1]
    end else if (!comp && start_q[ST_CH4]) begin
      cnt4_q <= cnt4_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_q <= REG_RST;
    end else if (whit(OFS_PERIOD)) begin
      per_q <= wmerge(per_q, wb_dat_i, wb_sel_i);  // [R4]
    end
  end

  // Transition, buffer and output state per pair
  for (genvar g = 0; g < 3; g++) begin : g_pair
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        buf_q[g] <= REG_RST;
      end else if (whit(OFS_BUF1 + 8'(g * 4))) begin
        buf_q[g] <= wmerge(buf_q[g], wb_dat_i, wb_sel_i);
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tr_q[g] <= REG_RST;
      end else if (xfer) begin
        tr_q[g] <= buf_q[g];  // [R16]
      end else if (whit(OFS_TR1 + 8'(g * 4))) begin
        tr_q[g] <= wmerge(tr_q[g], wb_dat_i, wb_sel_i);  // [R5]
      end
    end

    // Lead counter moves primary, lag counter the complement
    always_ff @(posedge clk_i) begin
      if (rst_i || !comp) begin
        pv_q[g] <= 1'b1;
        cv_q[g] <= 1'b0;
      end else if (run34 && tr_q[g] <= per_q) begin  // [R14]
        if (!dir_q) begin
          if (cnt3_q == tr_q[g]) begin
            pv_q[g] <= 1'b0;  // [R13] [R24]
          end
          if (cnt4_q == tr_q[g]) begin
            cv_q[g] <= 1'b1;  // [R13] [R24]
          end
        end else begin
          if (cnt4_q == tr_q[g]) begin
            cv_q[g] <= 1'b0;  // [R13] [R24]
          end
          if (cnt3_q == tr_q[g]) begin
            pv_q[g] <= 1'b1;  // [R13] [R24]
          end
        end
      end
    end
  end

  // Pins, with level select; idle low outside the mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm1_out_o       <= 1'b0;
      pwm1_compl_out_o <= 1'b0;
      pwm2_out_o       <= 1'b0;
      pwm2_compl_out_o <= 1'b0;
      pwm3_out_o       <= 1'b0;
      pwm3_compl_out_o <= 1'b0;
    end else begin
      // Out-of-range value never matches, level stays put [R14]
      pwm1_out_o       <= comp & (pv_q[0] ^ ~lvl_q[0]);  // [R2] [R26]
      pwm1_compl_out_o <= comp & (cv_q[0] ^ ~lvl_q[0]);  // [R2] [R26]
      pwm2_out_o       <= comp & (pv_q[1] ^ ~lvl_q[1]);  // [R2] [R26]
      pwm2_compl_out_o <= comp & (cv_q[1] ^ ~lvl_q[1]);  // [R2] [R26]
      pwm3_out_o       <= comp & (pv_q[2] ^ ~lvl_q[2 - 1]);  // [R2] [R26]
      pwm3_compl_out_o <= comp & (cv_q[2] ^ ~lvl_q[2 - 1]);  // [R2] [R26]
    end
  end

  // Quadrature edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exta_q <= 1'b0;
      extb_q <= 1'b0;
    end else begin
      exta_q <= ext_clock_a_i;
      extb_q <= ext_clock_b_i;
    end
  end

  assign edg.rise_a = ext_clock_a_i & ~exta_q;  // [R21]
  assign edg.fall_a = ~ext_clock_a_i & exta_q;  // [R21]
  assign edg.rise_b = ext_clock_b_i & ~extb_q;  // [R21]
  assign edg.fall_b = ~ext_clock_b_i & extb_q;  // [R21]

  // Channel 2 count steps; phase mode ignores clock select [R22]
  always_comb begin
    up2 = 1'b0;
    dn2 = 1'b0;
    if (start_q[ST_CH2]) begin
      if (mode_q[MD_PHASE]) begin
        up2 = (edg.rise_b & ~ext_clock_a_i) | (edg.rise_a & ext_clock_b_i)
            | (edg.fall_b & ext_clock_a_i) | (edg.fall_a & ~ext_clock_b_i);
        dn2 = (edg.rise_b & ext_clock_a_i) | (edg.rise_a & ~ext_clock_b_i)
            | (edg.fall_b & ~ext_clock_a_i) | (edg.fall_a & ext_clock_b_i);
      end else begin
        up2 = 1'b1;
      end
    end
  end

  // Step, compare matches and counter clear of channel 2
  assign step2 = up2 | dn2;
  assign ma2   = step2 & (cnt2_q == cmpa2_q);
  assign mb2   = step2 & (cnt2_q == cmpb2_q);
  assign clr2  = (ma2 & (clr2_q == CLR_A)) | (mb2 & (clr2_q == CLR_B));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt2_q <= CNT_ZERO;
    end else if (whit(OFS_CNT2)) begin
      cnt2_q <= wmerge(cnt2_q, wb_dat_i, wb_sel_i);
    end else if (clr2) begin
      cnt2_q <= CNT_ZERO;  // [R22]
    end else if (up2) begin
      cnt2_q <= cnt2_q + 1'b1;  // [R21]
    end else if (dn2) begin
      cnt2_q <= cnt2_q - 1'b1;  // [R21]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpa2_q <= REG_RST;
      cmpb2_q <= REG_RST;
    end else begin
      if (whit(OFS_CMPA2)) begin
        cmpa2_q <= wmerge(cmpa2_q, wb_dat_i, wb_sel_i);
      end
      if (whit(OFS_CMPB2)) begin
        cmpb2_q <= wmerge(cmpb2_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Flag sources
  always_comb begin
    fset       = '0;
    fset.cmpa3 = comp ? m3up
                      : start_q[ST_CH3] & (cnt3_q == per_q);  // [R15]
    fset.ovf4  = comp ? uf4
                      : start_q[ST_CH4] & (cnt4_q == CNT_MAX);  // [R15] [R25]
    fset.cmpa2 = ma2;  // [R22]
    fset.cmpb2 = mb2;  // [R22]
    fset.ovf2  = (up2 & (cnt2_q == CNT_MAX))
               | (dn2 & (cnt2_q == CNT_ZERO));  // [R25]
  end

  // Writing zero clears a flag
  always_comb begin
    fclr = '0;
    if (whit(OFS_STATUS) && wb_sel_i[0]) begin
      fclr = ~flags_t'(wb_dat_i[4:0]);
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~fclr) | fset;
    end
  end

endmodule

/* test/cpwm_properties.sv */
`timescale 1ns/1ps
module cpwm_properties
  import cpwm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pwm1_out_o,
  input wire logic        pwm1_compl_out_o,
  input wire logic        pwm2_out_o,
  input wire logic        pwm2_compl_out_o,
  input wire logic        pwm3_out_o,
  input wire logic        pwm3_compl_out_o
);
  logic [1:0] lvl_q;
  logic [1:0] comb_q;
  logic [2:0] off_q;
  logic       wr;
  logic [5:0] pins;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
              && wb_sel_i[0];
  assign pins = {pwm1_out_o, pwm1_compl_out_o, pwm2_out_o,
                 pwm2_compl_out_o, pwm3_out_o, pwm3_compl_out_o};
  // Shadow of level bits and combination field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= LVL_RST;
      comb_q <= MODE_RST[1:0];
    end else if (wr && wb_adr_i == OFS_OUTCTL) begin
      lvl_q <= wb_dat_i[1:0];
    end else if (wr && wb_adr_i == OFS_MODE) begin
      comb_q <= wb_dat_i[1:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_q <= 3'h7;
    end else begin
      off_q <= {off_q[1:0], comb_q != COMB_COMPL};
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("stray ack");
  upper_zero_a: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved");
  reset_idle_a: assert property (
    $fell(rst_i) |-> !wb_ack_o && pins == 6'h00)
    else $error("busy after reset");
  idle_pins_a: assert property (&off_q |-> pins == 6'h00)
    else $error("pins out of mode");
  dead_one_a: assert property (
    lvl_q[0] && $past(lvl_q[0], 3) |-> !(pins[5] && pins[4]))
    else $error("pair 1 overlap");
  dead_two_a: assert property (
    lvl_q[1] && $past(lvl_q[1], 3) |-> !(pins[3] && pins[2]))
    else $error("pair 2 overlap");
  dead_three_a: assert property (
    lvl_q[1] && $past(lvl_q[1], 3) |-> !(pins[1] && pins[0]))
    else $error("pair 3 overlap");
endmodule
bind complementary_pwm_phase_count cpwm_properties i_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .pwm1_out_o, .pwm1_compl_out_o,
  .pwm2_out_o, .pwm2_compl_out_o, .pwm3_out_o, .pwm3_compl_out_o
);

/* test/quad_encoder.sv */
`timescale 1ns/1ps
module quad_encoder (
  input  wire logic clk_i,
  input  wire logic up_i,
  input  wire logic dn_i,
  output logic      a_o,
  output logic      b_o
);
  logic [1:0] ph_q = 2'h0;
  always_ff @(posedge clk_i) begin
    if (up_i) begin
      ph_q <= ph_q + 2'h1;
    end else if (dn_i) begin
      ph_q <= ph_q - 2'h1;
    end
  end
  // One line moves per step, forward order 00 01 11 10
  assign a_o = ph_q[1];
  assign b_o = ^ph_q;
endmodule

/* test/complementary_pwm_phase_count_tb.sv */
`timescale 1ns/1ps
module complementary_pwm_phase_count_tb
  import cpwm_pkg::*;
;
  localparam logic [31:0] TV [3] = '{32'h0000_0008, 32'h0000_000C,
                                     32'h0000_0028};
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic        wb_ack_o;
  logic        up;
  logic        dn;
  logic        ext_clock_a_i;
  logic        ext_clock_b_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] got;
  logic [5:0]  pins;
  int          errors;
  int          comparisons;
  complementary_pwm_phase_count i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .ext_clock_a_i, .ext_clock_b_i, .wb_dat_o, .wb_ack_o,
    .pwm1_out_o(pins[5]), .pwm1_compl_out_o(pins[4]),
    .pwm2_out_o(pins[3]), .pwm2_compl_out_o(pins[2]),
    .pwm3_out_o(pins[1]), .pwm3_compl_out_o(pins[0])
  );
  quad_encoder i_enc (.clk_i, .up_i(up), .dn_i(dn),
                      .a_o(ext_clock_a_i), .b_o(ext_clock_b_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h3;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    got = wb_dat_o;
    chk({31'h0000_0000, wb_ack_o}, 32'h0000_0001);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(got, e);
  endtask
  task automatic step(input logic u, input int n);
    repeat (n) begin
      up <= u;
      dn <= !u;
      @(posedge clk_i);
      up <= 1'b0;
      dn <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic meas(input int e [6]);
    int c [6];
    int x;
    c = '{default: 0};
    x = 0;
    repeat (102) begin
      @(posedge clk_i);
      x += int'($isunknown(pins));
      for (int i = 0; i < 6; i++) c[i] += int'(pins[5-i] === 1'b1);
    end
    for (int i = 0; i < 6; i++) chk(c[i], e[i]);
    chk(x, 0);
  endtask
  task automatic setup(input logic [3:0] md);
    wr(OFS_START, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0000);
    wr(OFS_MODE, {28'h000_0000, md});
    wr(OFS_CNT4, 32'h0000_0000);
    wr(OFS_CNT3, 32'h0000_0004);
    wr(OFS_PERIOD, 32'h0000_0013);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_TR1 + OFS_STEP * 8'(i), TV[i]);
      wr(OFS_BUF1 + OFS_STEP * 8'(i), TV[i]);
    end
    wr(OFS_START, 32'h0000_0006);
  endtask
  task automatic t_reset;
    rd(OFS_START, 32'(START_RST));
    rd(OFS_MODE, 32'(MODE_RST));
    rd(OFS_OUTCTL, 32'(LVL_RST));
    rd(OFS_CNT3, 32'(CNT_ZERO));
    rd(OFS_PERIOD, 32'(REG_RST));
    wr(8'h44, 32'h0000_1234);
    rd(8'h44, 32'h0000_0000);
  endtask
  task automatic t_modes;
    for (int c = 0; c < 3; c++) begin
      setup({2'h0, 2'(c)});
      meas('{0, 0, 0, 0, 0, 0});
    end
  endtask
  task automatic t_compl;
    setup(4'h3);
    repeat (68) @(posedge clk_i);
    meas('{30, 48, 54, 24, 102, 0});
    rd(OFS_STATUS, 32'h0000_0003);
    wr(OFS_OUTCTL, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    meas('{72, 54, 48, 78, 0, 102});
    wr(OFS_OUTCTL, 32'h0000_0003);
  endtask
  task automatic t_count;
    wr(OFS_MODE, 32'h0000_0000);
    wr(OFS_START, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0000);
    wr(OFS_CNT4, 32'h0000_FFF0);
    wr(OFS_START, 32'h0000_0005);
    repeat (30) @(posedge clk_i);
    rd(OFS_STATUS, 32'h0000_0002);
    rd(OFS_CNT2, 32'h0000_0023);
  endtask
  task automatic t_buffer;
    setup(4'h7);
    repeat (68) @(posedge clk_i);
    wr(OFS_BUF1, 32'h0000_000C);
    wr(OFS_BUF1 + 8'h08, 32'h0000_FFFF);
    repeat (68) @(posedge clk_i);
    rd(OFS_TR1, 32'h0000_000C);
    meas('{54, 24, 54, 24, 102, 0});
  endtask
  task automatic t_phase;
    wr(OFS_START, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0008);
    wr(OFS_STATUS, 32'h0000_0000);
    wr(OFS_CNT2, 32'h0000_0000);
    wr(OFS_CMPA2, 32'h0000_0002);
    wr(OFS_START, 32'h0000_0001);
    step(1'b1, 4);
    rd(OFS_CNT2, 32'h0000_0004);
    step(1'b0, 6);
    rd(OFS_CNT2, 32'h0000_FFFE);
    rd(OFS_STATUS, 32'h0000_001C);
    wr(OFS_CLR2, {30'h0000_0000, CLR_A});
    wr(OFS_CNT2, 32'h0000_0000);
    step(1'b1, 4);
    rd(OFS_CNT2, 32'h0000_0001);
    wr(OFS_CMPB2, 32'h0000_0001);
    rd(OFS_CMPB2, 32'h0000_0001);
    wr(OFS_CLR2, {30'h0000_0000, CLR_B});
    wr(OFS_CNT2, 32'h0000_0000);
    step(1'b1, 4);
    rd(OFS_CNT2, 32'h0000_0000);
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0000_0000;
    up = 1'b0;
    dn = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_modes;
    t_compl;
    t_count;
    t_buffer;
    t_phase;
    close_out;
  end
  initial begin
    #500_000;
    errors++;
    close_out;
  end
endmodule
